// >>> common/lfd_pkg.sv
package lfd_pkg;
    // register offsets
    localparam logic [7:0] SYSTEM_CONFIG_ADDR         = 8'h4A;
    localparam logic [7:0] FAULT_THRESHOLDS_ADDR      = 8'h4B;
    localparam logic [7:0] FAULT_ENABLES_ADDR         = 8'h4C;
    localparam logic [7:0] FAULT_RESPONSE_CONFIG_ADDR = 8'h4D;
    localparam logic [7:0] STRING_SHORT_FLAGS_LO_ADDR = 8'h4E;
    localparam logic [7:0] STRING_SHORT_FLAGS_HI_ADDR = 8'h4F;
    localparam logic [7:0] STRING_OPEN_FLAGS_LO_ADDR  = 8'h51;
    localparam logic [7:0] STRING_OPEN_FLAGS_HI_ADDR  = 8'h52;
    localparam logic [7:0] SINGLE_LED_FLAGS_LO_ADDR   = 8'h54;
    localparam logic [7:0] SINGLE_LED_FLAGS_HI_ADDR   = 8'h55;

    // reset values
    localparam logic [7:0] SYSTEM_CONFIG_RST          = 8'h08;
    localparam logic [7:0] FAULT_THRESHOLDS_RST       = 8'h04;
    localparam logic [7:0] FAULT_ENABLES_RST          = 8'h0F;
    localparam logic [7:0] FAULT_RESPONSE_CONFIG_RST  = 8'h63;
    localparam logic [7:0] FLAGS_RST                  = 8'h00;

    // writable bits per register
    localparam logic [7:0] SYSTEM_CONFIG_MASK         = 8'hFF;
    localparam logic [7:0] FAULT_THRESHOLDS_MASK      = 8'h7F;
    localparam logic [7:0] FAULT_ENABLES_MASK         = 8'h3F;
    localparam logic [7:0] FAULT_RESPONSE_MASK        = 8'h7F;

    // system_config fields
    localparam int SPREAD_ON_BIT     = 7;
    localparam int SPREAD_RANGE_LSB  = 5;
    localparam int WRITE_ACK_EN_BIT  = 4;
    localparam int WDT_TAP_LSB       = 1;
    localparam int PWR_MARKER_BIT    = 0;

    // fault_thresholds fields
    localparam int STR_SHORT_TH_LSB  = 4;
    localparam int SUPPLY_FLOOR_LSB  = 0;

    // fault_enables fields
    localparam int SINGLE_REPORT_BIT = 5;
    localparam int SINGLE_DETECT_BIT = 4;
    localparam int SHORT_REPORT_BIT  = 3;
    localparam int SHORT_DETECT_BIT  = 2;
    localparam int OPEN_REPORT_BIT   = 1;
    localparam int OPEN_DETECT_BIT   = 0;

    // fault_response_config fields
    localparam int SHORT_CUT_BIT     = 6;
    localparam int OPEN_CUT_BIT      = 5;
    localparam int SINGLE_CUT_BIT    = 4;
    localparam int DELAY_CODE_LSB    = 0;

    // flag layout: six channels per register
    localparam int CH_PER_REG        = 6;
    localparam int NUM_CH            = 12;

    localparam logic [7:0] WRITE_ACK_BYTE = 8'h7F;

    // timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int WDT_BASE_MS       = 8;
    localparam int WDT_COUNT_W       = 24;
    localparam int WDT_TAP_BASE      = 5;
    localparam int WDT_TICK_CYC      = (WDT_BASE_MS * 1000000) / ((1 << WDT_TAP_BASE) * CLK_PERIOD_NS);
    localparam int DLY_SHORT_NS      = 32000;
    localparam int DLY_LONG_NS       = 7812500;
    localparam int DLY_SHORT_CYC     = (DLY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_LONG_CYC      = (DLY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_CODE_SPLIT    = 8;
    localparam int DLY_CNT_W         = 26;
endpackage

// >>> logic/lfd_watchdog.sv
`timescale 1ns/1ns
module lfd_watchdog #(
    parameter int TICK_CYC = lfd_pkg::WDT_TICK_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       kick_i,
    input  wire logic [2:0] tap_i,
    output logic            timeout_o
);
    logic [lfd_pkg::WDT_COUNT_W-1:0] cnt_reg;
    logic [15:0]                     pre_reg;
    logic                            tick;
    logic [4:0]                      tap_bit;
    logic                            hit;

    assign tick    = (pre_reg == 16'(TICK_CYC - 1));
    assign tap_bit = 5'(lfd_pkg::WDT_TAP_BASE) + {2'h0, tap_i};
    assign hit     = cnt_reg[tap_bit];

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg   <= '0;
            pre_reg   <= '0;
            timeout_o <= 1'b0;
        end else if (ce_i) begin
            if (kick_i) begin
                cnt_reg   <= '0;
                pre_reg   <= '0;
                timeout_o <= 1'b0;
            end else begin
                pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
                if (tick && !timeout_o)
                    cnt_reg <= cnt_reg + 24'h000001;
                if (hit)
                    timeout_o <= 1'b1;
            end
        end
    end
endmodule

// >>> logic/lfd_regs.sv
`timescale 1ns/1ns
// Contract
// - ack byte 7F after writes when enabled
// - power marker clears at reset, host sets
// - watchdog is 24-bit, tap selects bit
// - tap codes 8ms doubling, default 128ms
// - spread range field selects four ranges
// - supply floor code gates open/single detect
// - string short threshold code, 111 reserved
// - three detect enables gate detection
// - three report enables drive fault pin
// - report delay code sets fault delay
// - current cut bits reduce faulted channel
// - per-channel flags show channel faults
module lfd_regs #(
    parameter int WDT_TICK_CYC  = lfd_pkg::WDT_TICK_CYC,
    parameter int DLY_SHORT_CYC = lfd_pkg::DLY_SHORT_CYC,
    parameter int DLY_LONG_CYC  = lfd_pkg::DLY_LONG_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // decoded command port from the link receiver
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic [7:0]       reg_rdata_o,
    output logic             reg_rvalid_o,
    output logic             ack_req_o,
    output logic [7:0]       ack_byte_o,
    // analog front end
    input  wire logic [11:0] raw_string_short_i,
    input  wire logic [11:0] raw_string_open_i,
    input  wire logic [11:0] raw_single_short_i,
    input  wire logic        supply_above_floor_i,
    output logic [3:0]       detect_supply_floor_o,
    output logic [2:0]       string_short_threshold_o,
    output logic             spread_spectrum_on_o,
    output logic [1:0]       spread_range_select_o,
    output logic [11:0]      current_cut_o,
    output logic             wdt_timeout_o,
    output logic             fault_pin_n_o
);
    logic [7:0]  system_config_reg;
    logic [7:0]  fault_thresholds_reg;
    logic [7:0]  fault_enables_reg;
    logic [7:0]  fault_response_config_reg;
    logic [11:0] channel_string_short_flag_reg;
    logic [11:0] channel_string_open_flag_reg;
    logic [11:0] channel_single_short_flag_reg;
    localparam int DLY_CNT_W_L = lfd_pkg::DLY_CNT_W;

    logic [DLY_CNT_W_L-1:0] dly_cnt_reg;

    // six-channel slice of a flag vector into a register byte
    function automatic logic [7:0] flag_half(input logic [11:0] flags, input logic hi);
        flag_half = {2'h0, hi ? flags[11:6] : flags[5:0]};
    endfunction

    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target);
        wr_hit = (addr == target);
    endfunction

    wire wr_sys   = reg_wr_i && wr_hit(reg_addr_i, lfd_pkg::SYSTEM_CONFIG_ADDR);
    wire wr_thr   = reg_wr_i && wr_hit(reg_addr_i, lfd_pkg::FAULT_THRESHOLDS_ADDR);
    wire wr_en    = reg_wr_i && wr_hit(reg_addr_i, lfd_pkg::FAULT_ENABLES_ADDR);
    wire wr_resp  = reg_wr_i && wr_hit(reg_addr_i, lfd_pkg::FAULT_RESPONSE_CONFIG_ADDR);

    // enable fields
    wire single_report_en = fault_enables_reg[lfd_pkg::SINGLE_REPORT_BIT];
    wire single_detect_en = fault_enables_reg[lfd_pkg::SINGLE_DETECT_BIT];
    wire short_report_en  = fault_enables_reg[lfd_pkg::SHORT_REPORT_BIT];
    wire short_detect_en  = fault_enables_reg[lfd_pkg::SHORT_DETECT_BIT];
    wire open_report_en   = fault_enables_reg[lfd_pkg::OPEN_REPORT_BIT];
    wire open_detect_en   = fault_enables_reg[lfd_pkg::OPEN_DETECT_BIT];

    wire       short_cut_en  = fault_response_config_reg[lfd_pkg::SHORT_CUT_BIT];
    wire       open_cut_en   = fault_response_config_reg[lfd_pkg::OPEN_CUT_BIT];
    wire       single_cut_en = fault_response_config_reg[lfd_pkg::SINGLE_CUT_BIT];
    wire [3:0] delay_code    = fault_response_config_reg[lfd_pkg::DELAY_CODE_LSB +: 4];

    // below supply floor, open and single-short are masked
    wire [11:0] short_next  = short_detect_en ? raw_string_short_i : 12'h000;
    wire [11:0] open_next   = (open_detect_en && supply_above_floor_i) ? raw_string_open_i : 12'h000;
    wire [11:0] single_next = (single_detect_en && supply_above_floor_i) ? raw_single_short_i : 12'h000;

    wire report_any = (short_report_en && |channel_string_short_flag_reg)
                   || (open_report_en && |channel_string_open_flag_reg)
                   || (single_report_en && |channel_single_short_flag_reg);

    wire [3:0] long_shift = delay_code - 4'(lfd_pkg::DLY_CODE_SPLIT);
    wire [DLY_CNT_W_L-1:0] dly_short_base = DLY_CNT_W_L'(DLY_SHORT_CYC);
    wire [DLY_CNT_W_L-1:0] dly_long_base  = DLY_CNT_W_L'(DLY_LONG_CYC);
    wire [DLY_CNT_W_L-1:0] dly_target = delay_code[3] ? (dly_long_base << long_shift[2:0])
                                                      : (dly_short_base << delay_code[2:0]);
    wire dly_done = (dly_cnt_reg >= dly_target);

    wire [11:0] cut_next = (channel_string_short_flag_reg & {12{short_cut_en}})
                         | (channel_string_open_flag_reg  & {12{open_cut_en}})
                         | (channel_single_short_flag_reg & {12{single_cut_en}});

    // read mux, bits 7:6 of flag registers read zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr_i)
            lfd_pkg::SYSTEM_CONFIG_ADDR:         rd_mux = system_config_reg;
            lfd_pkg::FAULT_THRESHOLDS_ADDR:      rd_mux = fault_thresholds_reg;
            lfd_pkg::FAULT_ENABLES_ADDR:         rd_mux = fault_enables_reg;
            lfd_pkg::FAULT_RESPONSE_CONFIG_ADDR: rd_mux = fault_response_config_reg;
            lfd_pkg::STRING_SHORT_FLAGS_LO_ADDR: rd_mux = flag_half(channel_string_short_flag_reg, 1'b0);
            lfd_pkg::STRING_SHORT_FLAGS_HI_ADDR: rd_mux = flag_half(channel_string_short_flag_reg, 1'b1);
            lfd_pkg::STRING_OPEN_FLAGS_LO_ADDR:  rd_mux = flag_half(channel_string_open_flag_reg, 1'b0);
            lfd_pkg::STRING_OPEN_FLAGS_HI_ADDR:  rd_mux = flag_half(channel_string_open_flag_reg, 1'b1);
            lfd_pkg::SINGLE_LED_FLAGS_LO_ADDR:   rd_mux = flag_half(channel_single_short_flag_reg, 1'b0);
            lfd_pkg::SINGLE_LED_FLAGS_HI_ADDR:   rd_mux = flag_half(channel_single_short_flag_reg, 1'b1);
            default:                             rd_mux = 8'h00;
        endcase
    end

    // marker bit clears at reset or when the host writes it zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            system_config_reg         <= lfd_pkg::SYSTEM_CONFIG_RST;
            fault_thresholds_reg      <= lfd_pkg::FAULT_THRESHOLDS_RST;
            fault_enables_reg         <= lfd_pkg::FAULT_ENABLES_RST;
            fault_response_config_reg <= lfd_pkg::FAULT_RESPONSE_CONFIG_RST;
        end else if (ce_i) begin
            if (wr_sys)
                system_config_reg <= reg_wdata_i & lfd_pkg::SYSTEM_CONFIG_MASK;
            if (wr_thr)
                fault_thresholds_reg <= reg_wdata_i & lfd_pkg::FAULT_THRESHOLDS_MASK;
            if (wr_en)
                fault_enables_reg <= reg_wdata_i & lfd_pkg::FAULT_ENABLES_MASK;
            if (wr_resp)
                fault_response_config_reg <= reg_wdata_i & lfd_pkg::FAULT_RESPONSE_MASK;
        end
    end

    // flags follow the gated channel faults
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            channel_string_short_flag_reg <= 12'h000;
            channel_string_open_flag_reg  <= 12'h000;
            channel_single_short_flag_reg <= 12'h000;
            current_cut_o                 <= 12'h000;
        end else if (ce_i) begin
            channel_string_short_flag_reg <= short_next;
            channel_string_open_flag_reg  <= open_next;
            channel_single_short_flag_reg <= single_next;
            current_cut_o                 <= cut_next;
        end
    end

    // pin falls once reported fault outlasts delay
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            dly_cnt_reg   <= '0;
            fault_pin_n_o <= 1'b1;
        end else if (ce_i) begin
            if (!report_any) begin
                dly_cnt_reg   <= '0;
                fault_pin_n_o <= 1'b1;
            end else if (dly_done) begin
                fault_pin_n_o <= 1'b0;
            end else begin
                dly_cnt_reg <= dly_cnt_reg + DLY_CNT_W_L'(1);
            end
        end
    end

    // ack only when enabled, on every write, mapped address or not
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
            ack_req_o    <= 1'b0;
            ack_byte_o   <= 8'h00;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
                reg_rdata_o <= rd_mux;
            ack_req_o <= reg_wr_i && system_config_reg[lfd_pkg::WRITE_ACK_EN_BIT];
            if (reg_wr_i)
                ack_byte_o <= lfd_pkg::WRITE_ACK_BYTE;
        end
    end

    // threshold codes pass to the comparator, reserved code unchanged
    assign string_short_threshold_o = fault_thresholds_reg[lfd_pkg::STR_SHORT_TH_LSB +: 3];
    assign detect_supply_floor_o    = fault_thresholds_reg[lfd_pkg::SUPPLY_FLOOR_LSB +: 4];
    // range code straight to the modulator
    assign spread_range_select_o    = system_config_reg[lfd_pkg::SPREAD_RANGE_LSB +: 2];
    // no 244Hz interlock, host keeps it
    assign spread_spectrum_on_o     = system_config_reg[lfd_pkg::SPREAD_ON_BIT];

    // any command restarts the link watchdog
    // 24-bit counter with tap select
    lfd_watchdog #(
        .TICK_CYC (WDT_TICK_CYC)
    ) u_wdt (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .kick_i     (reg_wr_i || reg_rd_i),
        .tap_i      (system_config_reg[lfd_pkg::WDT_TAP_LSB +: 3]),
        .timeout_o  (wdt_timeout_o)
    );
endmodule

// >>> dv/lfd_regs_monitor.sv
`timescale 1ns/1ns
module lfd_regs_monitor (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic        ack_req_o,
    input wire logic [7:0]  ack_byte_o,
    input wire logic [11:0] raw_string_short_i,
    input wire logic [11:0] raw_string_open_i,
    input wire logic [11:0] raw_single_short_i,
    input wire logic [3:0]  detect_supply_floor_o,
    input wire logic [2:0]  string_short_threshold_o,
    input wire logic        spread_spectrum_on_o,
    input wire logic [1:0]  spread_range_select_o,
    input wire logic [11:0] current_cut_o,
    input wire logic        wdt_timeout_o,
    input wire logic        fault_pin_n_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic        rd  = reg_rd_i & ce_i & ~reg_wr_i;
    wire logic [11:0] raw = raw_string_short_i | raw_string_open_i | raw_single_short_i;
    ack_byte_a: assert property (ack_req_o |-> ack_byte_o == 8'h7F) else $error("ack byte wrong");
    ack_cause_a: assert property (ack_req_o |-> $past(reg_wr_i & ce_i)) else $error("ack without write");
    flag_top_a: assert property (rd && reg_addr_i inside {8'h4E, 8'h4F, 8'h51, 8'h52, 8'h54, 8'h55}
        |=> reg_rvalid_o && reg_rdata_o[7:6] == 2'b00) else $error("flag read layout wrong");
    thresh_read_a: assert property (rd && reg_addr_i == 8'h4B
        |=> reg_rdata_o == {1'b0, string_short_threshold_o, detect_supply_floor_o}) else $error("threshold fields");
    spread_read_a: assert property (rd && reg_addr_i == 8'h4A
        |=> reg_rdata_o[7:5] == {spread_spectrum_on_o, spread_range_select_o}) else $error("spread fields");
    cut_cause_a: assert property (current_cut_o != 12'h000
        |-> ($past(raw, 2) & current_cut_o) == current_cut_o) else $error("cut without fault");
    pin_cause_a: assert property (!fault_pin_n_o |-> $past(raw, 3) != 12'h000) else $error("pin without fault");
    wdt_clear_a: assert property ((reg_wr_i | reg_rd_i) && ce_i |-> ##[1:2] !wdt_timeout_o) else $error("no kick");
    cover property (ack_req_o);
    cover property (!fault_pin_n_o);
    cover property (wdt_timeout_o);
endmodule
bind lfd_regs lfd_regs_monitor u_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .ack_req_o(ack_req_o), .ack_byte_o(ack_byte_o), .raw_string_short_i(raw_string_short_i),
    .raw_string_open_i(raw_string_open_i), .raw_single_short_i(raw_single_short_i),
    .detect_supply_floor_o(detect_supply_floor_o), .string_short_threshold_o(string_short_threshold_o),
    .spread_spectrum_on_o(spread_spectrum_on_o), .spread_range_select_o(spread_range_select_o),
    .current_cut_o(current_cut_o), .wdt_timeout_o(wdt_timeout_o), .fault_pin_n_o(fault_pin_n_o));

// >>> dv/lfd_host_model.sv
`timescale 1ns/1ns
module lfd_host_model (
    input  wire logic       core_clk_i,
    input  wire logic       go_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] data_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o
);
    wire logic       cfg  = addr_i == lfd_pkg::SYSTEM_CONFIG_ADDR;
    wire logic       thr  = addr_i == lfd_pkg::FAULT_THRESHOLDS_ADDR && data_i[6:4] == 3'h7;
    wire logic [7:0] safe = cfg ? (data_i & 8'h7F) : (thr ? (data_i & 8'hEF) : data_i);
    // idle bus shows inverted value, never stale
    always_ff @(posedge core_clk_i) begin
        reg_wr_o    <= go_i & wr_i;
        reg_rd_o    <= go_i & ~wr_i;
        reg_addr_o  <= go_i ? addr_i : ~addr_i;
        reg_wdata_o <= go_i ? safe : ~safe;
    end
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] k;} lfd_row_s;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        go         = 1'b0;
    logic        wr         = 1'b0;
    logic [7:0]  addr       = 8'h00;
    logic [7:0]  data       = 8'h00;
    logic [11:0] raw_sh     = 12'h000;
    logic [11:0] raw_op     = 12'h000;
    logic [11:0] raw_sl     = 12'h000;
    logic        supply_ok  = 1'b1;
    logic        ce         = 1'b1;
    logic        reg_wr, reg_rd, rvalid, ack_req, spread_on, wdt_to, pin_n;
    logic [7:0]  reg_addr, reg_wdata, rdata, ack_byte;
    logic [3:0]  floor_code;
    logic [2:0]  thresh;
    logic [1:0]  range;
    logic [11:0] cut;
    int          errors     = 0;
    int          cmp_count  = 0;
    // k: 0 no ack, 1 ack, 2 not checked
    lfd_row_s rows [12] = '{'{1'b0, 8'h4A, 8'h00, 8'h08, 2'd2}, '{1'b0, 8'h4B, 8'h00, 8'h04, 2'd2},
        '{1'b0, 8'h4C, 8'h00, 8'h0F, 2'd2}, '{1'b0, 8'h4D, 8'h00, 8'h63, 2'd2}, '{1'b0, 8'h4E, 8'h00, 8'h00, 2'd2},
        '{1'b0, 8'h55, 8'h00, 8'h00, 2'd2}, '{1'b1, 8'h4B, 8'hFF, 8'h6F, 2'd0}, '{1'b1, 8'h4A, 8'h9F, 8'h1F, 2'd2},
        '{1'b1, 8'h4C, 8'hFF, 8'h3F, 2'd1}, '{1'b1, 8'h4D, 8'h5A, 8'h5A, 2'd1}, '{1'b1, 8'h52, 8'hFF, 8'h00, 2'd2},
        '{1'b1, 8'h50, 8'hFF, 8'h00, 2'd2}};
    lfd_host_model u_host (.core_clk_i(core_clk_i), .go_i(go), .wr_i(wr), .addr_i(addr), .data_i(data),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
    lfd_regs #(.WDT_TICK_CYC(4), .DLY_SHORT_CYC(2), .DLY_LONG_CYC(8)) DUT (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .ce_i(ce), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .ack_req_o(ack_req),
        .ack_byte_o(ack_byte), .raw_string_short_i(raw_sh), .raw_string_open_i(raw_op), .raw_single_short_i(raw_sl),
        .supply_above_floor_i(supply_ok), .detect_supply_floor_o(floor_code), .string_short_threshold_o(thresh),
        .spread_spectrum_on_o(spread_on), .spread_range_select_o(range), .current_cut_o(cut),
        .wdt_timeout_o(wdt_to), .fault_pin_n_o(pin_n));
    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic complete_run();
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // answer lands one edge after the host samples go
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr <= w;
        addr <= a;
        data <= d;
        go <= 1'b1;
        @(posedge core_clk_i);
        go <= 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(12'(rvalid), 12'h001);
        chk(12'(rdata), 12'(e));
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // cycles from the kicking access to the time-out flag
    task automatic wdt_chk(input int t);
        int n;
        n = 0;
        while (wdt_to !== 1'b1 && n < 4200) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk(12'(n >= 4 * (32 << t) - 8 && n <= 4 * (32 << t) + 8), 12'h001);
    endtask
    initial begin
        #(40 * 20000);
        errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].a, rows[i].d);
            if (rows[i].k != 2'd2) chk(12'(ack_req), 12'(rows[i].k));
            rd_chk(rows[i].a, rows[i].e);
        end
        chk(12'(ack_byte), 12'h07F);
        @(posedge core_clk_i);
        supply_ok <= 1'b0;
        raw_sh <= 12'h801;
        raw_op <= 12'h040;
        raw_sl <= 12'h020;
        rd_chk(8'h4E, 8'h01);
        rd_chk(8'h4F, 8'h20);
        rd_chk(8'h52, 8'h00);
        rd_chk(8'h54, 8'h00);
        @(posedge core_clk_i);
        supply_ok <= 1'b1;
        rd_chk(8'h52, 8'h01);
        rd_chk(8'h55, 8'h00);
        rd_chk(8'h54, 8'h20);
        chk(cut, 12'h821);
        acc(1'b1, 8'h4C, 8'h00);
        rd_chk(8'h4E, 8'h00);
        @(posedge core_clk_i);
        raw_op <= 12'h000;
        raw_sl <= 12'h000;
        raw_sh <= 12'h000;
        acc(1'b1, 8'h4C, 8'h3F);
        // short code 3 and long code 9 both give 16 cycles here
        for (int j = 0; j < 2; j++) begin
            acc(1'b1, 8'h4D, j ? 8'h49 : 8'h43);
            @(posedge core_clk_i);
            raw_sh <= 12'h001;
            wait_cyc(14);
            chk(12'(pin_n), 12'h001);
            wait_cyc(16);
            chk(12'(pin_n), 12'h000);
            @(posedge core_clk_i);
            raw_sh <= 12'h000;
        end
        acc(1'b1, 8'h4C, 8'h37);
        @(posedge core_clk_i);
        raw_sh <= 12'h001;
        wait_cyc(40);
        chk(12'(pin_n), 12'h001);
        for (int t = 0; t < 3; t++) begin
            acc(1'b1, 8'h4A, 8'(8'h11 + 2 * t));
            wdt_chk(t);
        end
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, 8'h4A, {1'b1, 2'(i), 5'h10});
            acc(1'b1, 8'h4B, {1'b0, 3'(i), 4'(i + 8)});
            chk(12'(range), 12'(i % 4));
            chk(12'(spread_on), 12'h000);
            chk(12'(thresh), (i == 7) ? 12'h006 : 12'(i));
            chk(12'(floor_code), 12'(i + 8));
        end
        // a write while the enable is low must be lost, with no ack
        @(posedge core_clk_i);
        ce <= 1'b0;
        acc(1'b1, 8'h4D, 8'h00);
        chk(12'(ack_req), 12'h000);
        @(posedge core_clk_i);
        ce <= 1'b1;
        rd_chk(8'h4D, 8'h49);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd_chk(8'h4A, 8'h08);
        wdt_chk(4);
        complete_run();
    end
endmodule
